// ==== host_misc_regs.sv ====
// host controller misc and list buffer control registers on classic wishbone
// assumes list buffer levels come from controller logic on the same clock
// Operation
// [R1] identity word returned at code 27; upper byte names the product
// [R2] identity lower byte is the silicon revision, engineering samples included
// [R3] scratch word written at A8, read at 28, resets to zero
// [R4] writing F6H at code A9 triggers a controller reset
// [R5] soft reset restores all registers, buffer memory left untouched
// [R6] any other value written at A9 changes nothing
// [R7] one iso list buffer size, read 2A, written AA, shared by both
// [R8] ack list buffer size, read 2B, written AB, resets to zero
// [R9] software keeps ack size plus twice iso size within 1000H bytes
// [R10] buffer status word read at 2C, bits 15 to 6 read zero
// [R11] bits 5,4,3 show ack, second iso, first iso buffer consumed
// [R12] bits 2,1,0 show ack, second iso, first iso buffer full
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "host_misc_defs.svh"
module host_misc_regs #(
  parameter int         ADDR_W          = 10,
  parameter logic [7:0] PRODUCT_CODE    = 8'h5a,  // arbitrary value
  parameter logic [7:0] SILICON_REVISION = 8'h01  // arbitrary value
) (
  // clock, reset, clock enable
  input  wire logic                       clock,
  input  wire logic                       reset_n,
  input  wire logic                       enable,
  // wishbone slave
  input  wire host_misc_pkg::wb_req_t     wbReq,
  output host_misc_pkg::wb_rsp_t          wbRsp,
  // list buffer levels from the controller
  input  wire host_misc_pkg::list_state_t listLevels,
  // configuration and control to the controller
  output logic [15:0]                     isoBufferSize,
  output logic [15:0]                     ackBufferSize,
  output logic                            hcSoftReset,
  output logic                            planOverflow,
  // interrupt
  output logic                            irq
);
  import host_misc_pkg::*;

  bank_state_t state_reg;
  bank_state_t state_next;

  logic [7:0]  regIndex;
  logic        request;
  logic        writeHit;
  logic        readHit;
  logic        keyMatch;
  logic        statusRead;
  logic [2:0]  consumedRise;
  logic [2:0]  eventStatus;
  logic [17:0] planBytes;
  logic [15:0] identityWord;
  logic [5:0]  listWord;

  initial begin
    if (ADDR_W < 10) $error("host_misc_regs needs ADDR_W >= 10");
  end

  // byte address is four times the register index
  assign regIndex = wbReq.adr[9:2];
  assign request  = wbReq.cyc & wbReq.stb & (state_reg.phase == PH_IDLE);
  assign writeHit = request & wbReq.we;
  assign readHit  = request & ~wbReq.we;

  // fixed identity: product in the high byte, revision in the low [R1] [R2]
  assign identityWord = {PRODUCT_CODE, SILICON_REVISION};

  // only the exact full-word key resets; other values are dropped [R4] [R6]
  assign keyMatch = writeHit & (regIndex == `IDX_SOFT_RESET_WRITE) &
                    (wbReq.sel[1:0] == 2'b11) &
                    (wbReq.dat[15:0] == `SOFT_RESET_KEY);

  assign statusRead = readHit & (regIndex == `IDX_EVENT_STATUS_READ);

  // status word layout: consumed in 5..3, loaded in 2..0 [R11] [R12]
  assign listWord = {state_reg.listCopy[5:3], state_reg.listCopy[2:0]};

  // total allocation check against the shared ram [R9]
  assign planBytes = {2'b00, state_reg.ackSize} + {1'b0, state_reg.isoSize, 1'b0};

  // byte-lane merge for 16-bit registers
  function automatic logic [15:0] laneMerge(
    input logic [15:0] oldValue,
    input logic [31:0] newValue,
    input logic [3:0]  lanes
  );
    logic [15:0] merged;
    merged       = oldValue;
    if (lanes[0]) begin
      merged[7:0] = newValue[7:0];
    end
    if (lanes[1]) begin
      merged[15:8] = newValue[15:8];
    end
    return merged;
  endfunction

  // a consumed edge is what raises an event
  rise_detect #(
    .WIDTH (3)
  ) u_rise (
    .clock   (clock),
    .reset_n (reset_n),
    .enable  (enable),
    .level   (listLevels.consumed),
    .rise    (consumedRise)
  );

  // event bits survive a read-clear in the same cycle
  event_sticky #(
    .WIDTH (3)
  ) u_events (
    .clock     (clock),
    .reset_n   (reset_n),
    .enable    (enable),
    .setBits   (consumedRise),
    .readClear (statusRead),
    .softClear (keyMatch),
    .status    (eventStatus)
  );

  always_comb begin
    state_next           = state_reg;
    state_next.softReset = 1'b0;
    // levels copied every enabled cycle so a read shows the live buffer state [R11] [R12]
    state_next.listCopy  = {listLevels.consumed, listLevels.loaded};
    state_next.overflow  = (planBytes > `LIST_RAM_BYTES);
    state_next.irq       = |(eventStatus & state_reg.mask);

    case (state_reg.phase)
      PH_IDLE: begin
        state_next.ack = 1'b0;
        if (request) begin
          state_next.ack    = 1'b1;
          state_next.phase  = PH_ACK;
          state_next.rdData = 32'h0000_0000;
          if (!wbReq.we) begin
            case (regIndex)
              `IDX_SILICON_IDENTITY: begin
                state_next.rdData = {16'h0000, identityWord}; // [R1] [R2]
              end
              `IDX_SCRATCH_READ: begin
                state_next.rdData = {16'h0000, state_reg.scratch}; // [R3]
              end
              `IDX_ISO_SIZE_READ: begin
                state_next.rdData = {16'h0000, state_reg.isoSize}; // [R7]
              end
              `IDX_ACK_SIZE_READ: begin
                state_next.rdData = {16'h0000, state_reg.ackSize}; // [R8]
              end
              `IDX_LIST_STATE_READ: begin
                // upper reserved bits held at zero [R10]
                state_next.rdData = {26'h000_0000, listWord};
              end
              `IDX_EVENT_STATUS_READ: begin
                state_next.rdData = {29'h0000_0000, eventStatus};
              end
              `IDX_EVENT_MASK_READ: begin
                state_next.rdData = {29'h0000_0000, state_reg.mask};
              end
              default: begin
                state_next.rdData = 32'h0000_0000;
              end
            endcase
          end else begin
            case (regIndex)
              `IDX_SCRATCH_WRITE: begin
                state_next.scratch = laneMerge(state_reg.scratch, wbReq.dat,
                                               wbReq.sel); // [R3]
              end
              `IDX_ISO_SIZE_WRITE: begin
                // one value serves both iso buffers [R7]
                state_next.isoSize = laneMerge(state_reg.isoSize, wbReq.dat,
                                               wbReq.sel);
              end
              `IDX_ACK_SIZE_WRITE: begin
                state_next.ackSize = laneMerge(state_reg.ackSize, wbReq.dat,
                                               wbReq.sel); // [R8]
              end
              `IDX_EVENT_MASK_WRITE: begin
                if (wbReq.sel[0]) begin
                  state_next.mask = wbReq.dat[2:0];
                end
              end
              default: begin
                // unmapped or read-only: acknowledged, nothing stored [R6]
                state_next.mask = state_reg.mask;
              end
            endcase
          end
        end
      end
      PH_ACK: begin
        // ack lasts one cycle; the master drops stb before the next request
        state_next.ack   = 1'b0;
        state_next.phase = PH_IDLE;
      end
      default: begin
        state_next.ack   = 1'b0;
        state_next.phase = PH_IDLE;
      end
    endcase

    // soft reset wins over the write path; buffer ram lives elsewhere [R4] [R5]
    if (keyMatch) begin
      state_next.scratch   = `RST_SCRATCH;
      state_next.isoSize   = `RST_ISO_SIZE;
      state_next.ackSize   = `RST_ACK_SIZE;
      state_next.mask      = `RST_EVENT_MASK;
      state_next.irq       = 1'b0;
      state_next.overflow  = 1'b0;
      state_next.softReset = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg          <= '0;
      state_reg.phase    <= PH_IDLE;
      state_reg.scratch  <= `RST_SCRATCH;  // [R3]
      state_reg.isoSize  <= `RST_ISO_SIZE;
      state_reg.ackSize  <= `RST_ACK_SIZE; // [R8]
      state_reg.mask     <= `RST_EVENT_MASK;
    end else if (enable) begin
      state_reg <= state_next;
    end
  end

  // every output straight from the state register
  assign wbRsp.ack     = state_reg.ack;
  assign wbRsp.dat     = state_reg.rdData;
  assign isoBufferSize = state_reg.isoSize;
  assign ackBufferSize = state_reg.ackSize;
  assign hcSoftReset   = state_reg.softReset;
  assign planOverflow  = state_reg.overflow;
  assign irq           = state_reg.irq;
endmodule
`default_nettype wire

// ==== host_misc_defs.svh ====
// register indices, field positions, reset values and keys of the host misc bank
// assumes a wishbone byte address of four times the register index
`ifndef HOST_MISC_DEFS_SVH
`define HOST_MISC_DEFS_SVH

// register indices (read codes; a write code is the read code with bit 7 set)
`define IDX_SILICON_IDENTITY     8'h27
`define IDX_SCRATCH_READ         8'h28
`define IDX_SCRATCH_WRITE        8'ha8
`define IDX_SOFT_RESET_WRITE     8'ha9
`define IDX_ISO_SIZE_READ        8'h2a
`define IDX_ISO_SIZE_WRITE       8'haa
`define IDX_ACK_SIZE_READ        8'h2b
`define IDX_ACK_SIZE_WRITE       8'hab
`define IDX_LIST_STATE_READ      8'h2c
`define IDX_EVENT_STATUS_READ    8'h30
`define IDX_EVENT_MASK_READ      8'h31
`define IDX_EVENT_MASK_WRITE     8'hb1

// list_buffer_state field positions
`define POS_ISO_FIRST_LOADED     0
`define POS_ISO_SECOND_LOADED    1
`define POS_ACK_LOADED           2
`define POS_ISO_FIRST_CONSUMED   3
`define POS_ISO_SECOND_CONSUMED  4
`define POS_ACK_CONSUMED         5

// reset values and keys
`define RST_SCRATCH              16'h0000
`define RST_ISO_SIZE             16'h0000
`define RST_ACK_SIZE             16'h0000
`define RST_EVENT_MASK           3'h0
`define SOFT_RESET_KEY           16'h00f6
`define LIST_RAM_BYTES           18'h01000

`endif

// ==== host_misc_pkg.sv ====
// types shared by the host misc register bank and its helpers
// assumes host_misc_defs.svh for all numeric constants
package host_misc_pkg;

  typedef enum logic [0:0] {
    PH_IDLE = 1'b0,
    PH_ACK  = 1'b1
  } bus_phase_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic [2:0] consumed;
    logic [2:0] loaded;
  } list_state_t;

  typedef struct packed {
    bus_phase_t  phase;
    logic        ack;
    logic [31:0] rdData;
    logic [15:0] scratch;
    logic [15:0] isoSize;
    logic [15:0] ackSize;
    logic [2:0]  mask;
    logic [5:0]  listCopy;
    logic        irq;
    logic        softReset;
    logic        overflow;
  } bank_state_t;

endpackage

// ==== rise_detect.sv ====
// per-bit rising edge finder with a registered one-cycle pulse out
// assumes inputs already on the clock domain
`timescale 1ns/1ps
`default_nettype none
module rise_detect #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             enable,
  // levels in, pulses out
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);
  typedef struct packed {
    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] rise;
  } edge_state_t;

  edge_state_t state_reg;
  edge_state_t state_next;

  initial begin
    if (WIDTH < 1) $error("rise_detect needs WIDTH >= 1");
  end

  always_comb begin
    state_next      = state_reg;
    state_next.prev = level;
    state_next.rise = level & ~state_reg.prev;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else if (enable) begin
      state_reg <= state_next;
    end
  end

  assign rise = state_reg.rise;
endmodule
`default_nettype wire

// ==== event_sticky.sv ====
// sticky event bits: set by pulses, cleared by a status read or a soft reset
// assumes clears are one-cycle pulses on the same clock
`timescale 1ns/1ps
`default_nettype none
module event_sticky #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             enable,
  // events and clears
  input  wire logic [WIDTH-1:0] setBits,
  input  wire logic             readClear,
  input  wire logic             softClear,
  output logic      [WIDTH-1:0] status
);
  typedef struct packed {
    logic [WIDTH-1:0] bits;
  } sticky_state_t;

  sticky_state_t    state_reg;
  sticky_state_t    state_next;
  logic [WIDTH-1:0] bitNext;

  initial begin
    if (WIDTH < 1) $error("event_sticky needs WIDTH >= 1");
  end

  // an event in the read-clear cycle survives; soft reset clears all
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign bitNext[i] = softClear ? 1'b0 :
                        (setBits[i] | (state_reg.bits[i] & ~readClear));
  end

  always_comb begin
    state_next      = state_reg;
    state_next.bits = bitNext;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else if (enable) begin
      state_reg <= state_next;
    end
  end

  assign status = state_reg.bits;
endmodule
`default_nettype wire

// ==== host_misc_regs_checker.sv ====
// concurrent checks on the host misc bank ports
// assumes one clock domain; bound to the design from the testbench file
`timescale 1ns/1ps
`default_nettype none
module host_misc_regs_checker #(
  parameter logic [7:0] PRODUCT_CODE     = 8'h5a,  // arbitrary value
  parameter logic [7:0] SILICON_REVISION = 8'h01   // arbitrary value
) (
  // clock and reset
  input wire logic                   clock,
  input wire logic                   reset_n,
  input wire logic                   enable,
  // register bus
  input wire host_misc_pkg::wb_req_t wbReq,
  input wire host_misc_pkg::wb_rsp_t wbRsp,
  // controller side
  input wire logic [15:0]            isoBufferSize,
  input wire logic [15:0]            ackBufferSize,
  input wire logic                   hcSoftReset
);
  import host_misc_pkg::*;
  logic       take;
  logic [7:0] idx;
  logic       wr16;
  logic       key;
  logic       isoWr;
  assign take = wbReq.cyc && wbReq.stb && !wbRsp.ack && enable;
  assign idx  = wbReq.adr[9:2];
  assign wr16 = take && wbReq.we && wbReq.sel[1:0] == 2'h3;
  assign key  = wr16 && idx == 8'ha9 && wbReq.dat[15:0] == 16'h00f6;
  assign isoWr = wr16 && idx == 8'haa;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence softDone;
    hcSoftReset ##0 isoBufferSize == 16'h0 ##0 ackBufferSize == 16'h0;
  endsequence
  sequence readOf(logic [7:0] i);
    take && !wbReq.we && idx == i;
  endsequence
  a_ack_after_take: assert property (take |=> wbRsp.ack)
    else $error("request not answered in one cycle");
  a_ack_one_pulse: assert property (wbRsp.ack |=> !wbRsp.ack)
    else $error("ack held past one cycle");
  a_ident_word: assert property (
    readOf(8'h27) |=> wbRsp.dat == {16'h0, PRODUCT_CODE, SILICON_REVISION})
    else $error("identity word wrong");
  a_state_reserved: assert property (readOf(8'h2c) |=> wbRsp.dat[31:6] == 26'h0)
    else $error("reserved status bits not zero");
  a_iso_size_write: assert property (
    wr16 && idx == 8'haa |=> isoBufferSize == $past(wbReq.dat[15:0]))
    else $error("iso size not stored");
  a_ack_size_write: assert property (
    wr16 && idx == 8'hab |=> ackBufferSize == $past(wbReq.dat[15:0]))
    else $error("ack size not stored");
  a_key_resets: assert property (key |=> softDone)
    else $error("key write did not reset");
  a_key_only: assert property (hcSoftReset |-> $past(key))
    else $error("reset pulse without key");
  a_iso_size_hold: assert property (
    $changed(isoBufferSize) |-> $past(key) || $past(isoWr))
    else $error("iso size changed without write");
endmodule
`default_nettype wire

// ==== list_level_model.sv ====
// controller side model: drives the list buffer levels into the bank
// assumes the bench sets the wanted level pattern by non-blocking assignment
`timescale 1ns/1ps
`default_nettype none
module list_level_model (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      reset_n,
  // wanted levels and controller reset
  input  wire logic [5:0]                want,
  input  wire logic                      hcSoftReset,
  output var host_misc_pkg::list_state_t listLevels
);
  import host_misc_pkg::*;
  // a controller reset empties every list buffer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      listLevels <= '0;
    end else if (hcSoftReset) begin
      listLevels <= '0;
    end else begin
      listLevels <= want;
    end
  end
endmodule
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the host misc bank over classic wishbone
// assumes the list level model stands for the controller side
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import host_misc_pkg::*;
  localparam logic [7:0] PROD = 8'h3c;  // arbitrary value
  localparam logic [7:0] REV  = 8'h07;  // arbitrary value
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        enable = 1'b1;
  wb_req_t     wbReq = '0;
  wb_rsp_t     wbRsp;
  list_state_t listLevels;
  logic [15:0] isoBufferSize;
  logic [15:0] ackBufferSize;
  logic        hcSoftReset;
  logic        planOverflow;
  logic        irq;
  logic [5:0]  want = '0;
  logic [15:0] rd;
  logic [15:0] pulses = '0;
  logic [7:0]  zeroIdx [7] = '{8'h28, 8'h2a, 8'h2b, 8'h2c, 8'h30, 8'h31, 8'h3f};
  int          n_mismatch = 0;
  int          cmp_count = 0;
  always #10 clock = ~clock;
  always @(posedge clock) if (hcSoftReset === 1'b1) pulses <= pulses + 16'h1;
  host_misc_regs #(.PRODUCT_CODE(PROD), .SILICON_REVISION(REV)) dut (
    .clock(clock), .reset_n(reset_n), .enable(enable), .wbReq(wbReq), .wbRsp(wbRsp),
    .listLevels(listLevels), .isoBufferSize(isoBufferSize), .ackBufferSize(ackBufferSize),
    .hcSoftReset(hcSoftReset), .planOverflow(planOverflow), .irq(irq));
  list_level_model model (.clock(clock), .reset_n(reset_n), .want(want),
    .hcSoftReset(hcSoftReset), .listLevels(listLevels));
  task automatic print_verdict();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // ack sampled at the rising edge; request held until that edge, released there
  task automatic bus(input logic we, input logic [7:0] idx, input logic [15:0] d,
                     input logic [1:0] sel);
    int n;
    @(posedge clock);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: {2'b00, sel},
               dat: {16'h0, d}};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wbRsp.ack !== 1'b1 && n < 20);
    rd = wbRsp.dat[15:0];
    wbReq <= '0;
    if (wbRsp.ack !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t no ack", $time);
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [15:0] d, input logic [1:0] sel);
    bus(1'b1, idx, d, sel);
  endtask
  task automatic rc(input logic [7:0] idx, input logic [15:0] exp);
    bus(1'b0, idx, 16'h0, 2'h3);
    chk(rd, exp);
  endtask
  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    foreach (zeroIdx[i]) rc(zeroIdx[i], 16'h0);
    rc(8'h27, {PROD, REV});
    wr(8'ha8, 16'hffff, 2'h3);
    wr(8'ha8, 16'h1234, 2'h1);
    rc(8'h28, 16'hff34);
    wr(8'h28, 16'h0, 2'h3);
    wr(8'h3f, 16'h0, 2'h3);
    rc(8'h28, 16'hff34);
    wr(8'hab, 16'h0800, 2'h3);
    wr(8'haa, 16'h0400, 2'h3);
    rc(8'h2a, 16'h0400);
    rc(8'h2b, 16'h0800);
    @(negedge clock);
    chk(isoBufferSize, 16'h0400);
    chk({15'h0, planOverflow}, 16'h0);
    // two bytes over the limit on purpose
    wr(8'haa, 16'h0401, 2'h3);
    repeat (2) @(negedge clock);
    chk({15'h0, planOverflow}, 16'h1);
    for (int i = 0; i < 6; i++) begin
      @(posedge clock);
      want <= 6'h1 << i;
      repeat (3) @(posedge clock);
      rc(8'h2c, 16'h1 << i);
    end
    @(negedge clock);
    chk({15'h0, irq}, 16'h0);
    wr(8'hb1, 16'h0007, 2'h3);
    repeat (3) @(negedge clock);
    chk({15'h0, irq}, 16'h1);
    rc(8'h30, 16'h0007);
    repeat (3) @(negedge clock);
    chk({15'h0, irq}, 16'h0);
    rc(8'h30, 16'h0);
    // frozen while enable is low: the consumed edge is only seen once it is back
    @(posedge clock);
    enable <= 1'b0;
    want <= 6'h28;
    repeat (4) @(negedge clock);
    chk({15'h0, irq}, 16'h0);
    @(posedge clock);
    enable <= 1'b1;
    repeat (4) @(negedge clock);
    chk({15'h0, irq}, 16'h1);
    rc(8'h30, 16'h0001);
    want <= 6'h0;
    wr(8'ha9, 16'h00f7, 2'h3);
    wr(8'ha9, 16'h00f6, 2'h1);
    rc(8'h28, 16'hff34);
    chk(pulses, 16'h0);
    wr(8'ha9, 16'h00f6, 2'h3);
    @(negedge clock);
    chk(pulses, 16'h1);
    foreach (zeroIdx[i]) rc(zeroIdx[i], 16'h0);
    chk(isoBufferSize, 16'h0);
    print_verdict();
  end
endmodule
bind host_misc_regs host_misc_regs_checker #(
  .PRODUCT_CODE(PRODUCT_CODE), .SILICON_REVISION(SILICON_REVISION)) checker_i (
  .clock(clock), .reset_n(reset_n), .enable(enable), .wbReq(wbReq), .wbRsp(wbRsp),
  .isoBufferSize(isoBufferSize), .ackBufferSize(ackBufferSize), .hcSoftReset(hcSoftReset));
`default_nettype wire
